//--- osss_map.svh
// Register map, field positions, reset values and timing counts for the clock source block
// Overview of operation
// R1 - Crystal modes count 1024 primary oscillator edges before the clock is stable
// R2 - Start-up count follows power-on after the power-up delay, and every wake-up
// R3 - Core is held, program counter frozen, while the start-up count runs
// R4 - External clock and RC modes wait two instruction cycles after sleep or reset
// R5 - Internal oscillator modes wait a warm-up delay after sleep or reset
// R6 - External clock mode runs no start-up timer count
// R7 - External clock mode takes clock on primary pin, frees secondary pin
// R8 - Logic is static; a stopped clock halts everything with state kept
// R9 - Amplifier gain is low, medium or high for the three crystal modes
// R10 - RC with clock output drives secondary pin with oscillator divided by four
// R11 - RC pin mode uses primary pin only; secondary pin becomes I/O
// R12 - Internal oscillator runs at 4 or 8 MHz by one select bit
// R13 - Internal with output frees primary pin, drives secondary with frequency over four
// R14 - Internal pins-free mode releases both oscillator pins as I/O
// R15 - Trim register holds 5-bit two's complement offset, zero after reset
// R16 - Trim 01111 is fastest, 00000 calibrated, 10000 slowest, monotonic
// R17 - New trim slews gradually, no stall and no completion flag
// R18 - Upper three trim register bits read as zero
// R19 - Clock mode comes from the 3-bit configuration source select field
// R20 - Eight modes: external, three crystal, two RC, two internal
// R21 - Select code to mode mapping is a parameter; start-up counter eleven bits
`ifndef OSSS_MAP_SVH
`define OSSS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OSSS_ADDR_TRIM        4'h0
`define OSSS_ADDR_STATUS      4'h1

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define OSSS_TRIM_MSB         4
`define OSSS_TRIM_RESET       5'h00
`define OSSS_MODE_MAP_DEFAULT 24'hFAC688

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define OSSS_STARTUP_EDGES    11'h400
`define OSSS_EXT_DELAY_EDGES  11'h008
`define OSSS_CLK_MHZ          250
`define OSSS_WARMUP_US        2
`define OSSS_WARMUP_CYCLES    (`OSSS_WARMUP_US * `OSSS_CLK_MHZ)
`define OSSS_INC_8MHZ         16'h0831
`define OSSS_INC_4MHZ         16'h0418
`define OSSS_SLEW_DIV         6'h3F

`endif

//--- osss_pkg.sv
// Types shared by the clock source block
package osss_pkg;

  typedef enum logic [2:0] {
    OSSS_EXT_CLOCK  = 3'b000,
    OSSS_LOW_XTAL   = 3'b001,
    OSSS_MED_XTAL   = 3'b010,
    OSSS_HIGH_XTAL  = 3'b011,
    OSSS_RC_DIVIDED_CLOCK_OUTPUT  = 3'b100,
    OSSS_RC_PIN     = 3'b101,
    OSSS_INT_DIVIDED_CLOCK_OUTPUT = 3'b110,
    OSSS_INT_PINS   = 3'b111
  } osss_mode_t;

  typedef enum logic [2:0] {
    OSSS_ST_CONFIG  = 3'b000,
    OSSS_ST_PWRUP   = 3'b001,
    OSSS_ST_DELAY   = 3'b010,
    OSSS_ST_RUN     = 3'b011,
    OSSS_ST_SLEEP   = 3'b100
  } osss_state_t;

  typedef enum logic [1:0] {
    OSSS_GAIN_OFF   = 2'b00,
    OSSS_GAIN_LOW   = 2'b01,
    OSSS_GAIN_MED   = 2'b10,
    OSSS_GAIN_HIGH  = 2'b11
  } osss_gain_t;

endpackage

//--- osss_top.sv
// Clock source selection, start-up sequencing, pin use and frequency trim
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "osss_map.svh"

module osss_top #(
  parameter logic [23:0] MODE_MAP = `OSSS_MODE_MAP_DEFAULT
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Configuration word fields
  input  wire logic [2:0] clock_source_select,
  input  wire logic       internal_frequency_select,
  input  wire logic       powerup_delay_timer_enable,
  // Power and sleep control
  input  wire logic       powerup_delay_timer_expired,
  input  wire logic       sleep_request,
  input  wire logic       wake_event,
  // Oscillator pins
  input  wire logic       primary_oscillator_pin_in,
  output logic            secondary_oscillator_pin_out,
  output logic            secondary_oscillator_pin_oe_n,
  output logic            primary_pin_gpio,
  output logic            secondary_pin_gpio,
  output logic [1:0]      amplifier_gain,
  // Core side
  output logic            core_hold,
  output logic            clock_stable,
  output logic            system_clock_enable,
  output logic [15:0]     internal_oscillator_increment,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic [7:0]      reg_rdata
);

  localparam logic [10:0] WARMUP_CYCLES = 11'(`OSSS_WARMUP_CYCLES);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  // R20 eight mode decode
  function automatic osss_pkg::osss_mode_t decode_mode(input logic [2:0] code);
    logic [2:0] m;
    m = MODE_MAP[code*3 +: 3];
    return osss_pkg::osss_mode_t'(m);
  endfunction

  function automatic logic is_crystal(input osss_pkg::osss_mode_t m);
    return (m == osss_pkg::OSSS_LOW_XTAL) || (m == osss_pkg::OSSS_MED_XTAL) ||
           (m == osss_pkg::OSSS_HIGH_XTAL);
  endfunction

  function automatic logic is_internal(input osss_pkg::osss_mode_t m);
    return (m == osss_pkg::OSSS_INT_DIVIDED_CLOCK_OUTPUT) || (m == osss_pkg::OSSS_INT_PINS);
  endfunction

  // ----------------------------------------
  // Configuration capture
  // ----------------------------------------
  osss_pkg::osss_mode_t mode_q;
  logic                 ifs_q;
  logic                 pdt_en_q;
  logic                 cfg_loaded_q;

  // R19 fixed mode capture
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q       <= osss_pkg::OSSS_EXT_CLOCK;
      ifs_q        <= 1'b0;
      pdt_en_q     <= 1'b0;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      // R21 parameter mapped decode
      mode_q       <= decode_mode(clock_source_select);
      ifs_q        <= internal_frequency_select;
      pdt_en_q     <= powerup_delay_timer_enable;
      cfg_loaded_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Frequency trim register
  // ----------------------------------------
  logic [4:0] trim_value_q;

  // R15 signed trim storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_value_q <= `OSSS_TRIM_RESET;
    end else if (reg_write && reg_addr == `OSSS_ADDR_TRIM) begin
      trim_value_q <= reg_wdata[`OSSS_TRIM_MSB:0];
    end
  end

  // ----------------------------------------
  // Internal oscillator model
  // ----------------------------------------
  logic [15:0] inc_target;
  logic [15:0] inc_q;
  logic [15:0] acc_q;
  logic [16:0] acc_sum;
  logic [5:0]  slew_cnt_q;
  logic        int_tick;

  // R12 R16 base rate plus monotonic trim offset
  always_comb begin
    inc_target = (ifs_q ? `OSSS_INC_8MHZ : `OSSS_INC_4MHZ) +
                 {{7{trim_value_q[4]}}, trim_value_q, 4'h0};
  end

  assign acc_sum  = {1'b0, acc_q} + {1'b0, inc_q};
  assign int_tick = acc_sum[16];

  // R17 gradual slew toward target
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slew_cnt_q <= 6'h00;
      inc_q      <= `OSSS_INC_4MHZ;
    end else if (!cfg_loaded_q) begin
      inc_q      <= internal_frequency_select ? `OSSS_INC_8MHZ : `OSSS_INC_4MHZ;
    end else begin
      slew_cnt_q <= slew_cnt_q + 6'h01;
      if (slew_cnt_q == `OSSS_SLEW_DIV) begin
        if (inc_q < inc_target) begin
          inc_q <= inc_q + 16'h0001;
        end else if (inc_q > inc_target) begin
          inc_q <= inc_q - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 16'h0000;
    end else if (is_internal(mode_q) && cfg_loaded_q) begin
      acc_q <= acc_sum[15:0];
    end
  end

  // ----------------------------------------
  // Oscillator edge detection
  // ----------------------------------------
  logic prim_prev_q;
  logic ext_tick;
  logic osc_tick;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prim_prev_q <= 1'b0;
    end else begin
      prim_prev_q <= primary_oscillator_pin_in;
    end
  end

  // R7 external clock taken from primary pin
  assign ext_tick = primary_oscillator_pin_in & ~prim_prev_q;
  assign osc_tick = cfg_loaded_q & (is_internal(mode_q) ? int_tick : ext_tick);

  // ----------------------------------------
  // Start-up sequencer
  // ----------------------------------------
  osss_pkg::osss_state_t state_q;
  logic [10:0]           delay_cnt_q;
  logic [10:0]           delay_len;
  logic                  delay_step;

  // R1 R4 R5 delay length by mode
  always_comb begin
    if (is_crystal(mode_q)) begin
      delay_len  = `OSSS_STARTUP_EDGES;
      delay_step = osc_tick;
    end else if (is_internal(mode_q)) begin
      delay_len  = WARMUP_CYCLES;
      delay_step = 1'b1;
    end else begin
      // R6 no start-up timer in external mode
      delay_len  = `OSSS_EXT_DELAY_EDGES;
      delay_step = osc_tick;
    end
  end

  // R2 start-up after power-up and wake
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= osss_pkg::OSSS_ST_CONFIG;
      delay_cnt_q <= 11'h000;
    end else begin
      case (state_q)
        osss_pkg::OSSS_ST_CONFIG: begin
          if (cfg_loaded_q) begin
            state_q <= osss_pkg::OSSS_ST_PWRUP;
          end
        end
        osss_pkg::OSSS_ST_PWRUP: begin
          if (!pdt_en_q || powerup_delay_timer_expired) begin
            state_q     <= osss_pkg::OSSS_ST_DELAY;
            delay_cnt_q <= 11'h000;
          end
        end
        osss_pkg::OSSS_ST_DELAY: begin
          // R8 count advances on oscillator edges, or on every cycle in internal modes
          if (delay_step) begin
            if (delay_cnt_q == delay_len - 11'h001) begin
              state_q <= osss_pkg::OSSS_ST_RUN;
            end else begin
              delay_cnt_q <= delay_cnt_q + 11'h001;
            end
          end
        end
        osss_pkg::OSSS_ST_RUN: begin
          if (sleep_request) begin
            state_q <= osss_pkg::OSSS_ST_SLEEP;
          end
        end
        osss_pkg::OSSS_ST_SLEEP: begin
          if (wake_event) begin
            state_q     <= osss_pkg::OSSS_ST_DELAY;
            delay_cnt_q <= 11'h000;
          end
        end
        default: begin
          state_q <= osss_pkg::OSSS_ST_CONFIG;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Core hold and clock enable
  // ----------------------------------------
  // R3 hold execution until running
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      core_hold    <= 1'b1;
      clock_stable <= 1'b0;
    end else begin
      core_hold    <= (state_q != osss_pkg::OSSS_ST_RUN);
      clock_stable <= (state_q == osss_pkg::OSSS_ST_RUN);
    end
  end

  // R8 no edge means no core progress
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      system_clock_enable <= 1'b0;
    end else begin
      system_clock_enable <= osc_tick && (state_q == osss_pkg::OSSS_ST_RUN);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      internal_oscillator_increment <= `OSSS_INC_4MHZ;
    end else begin
      internal_oscillator_increment <= inc_q;
    end
  end

  // ----------------------------------------
  // Divided clock output
  // ----------------------------------------
  logic [1:0] div_cnt_q;

  // R10 R13 oscillator divided by four
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 2'b00;
    end else if (osc_tick) begin
      div_cnt_q <= div_cnt_q + 2'b01;
    end
  end

  // ----------------------------------------
  // Pin functions and amplifier gain
  // ----------------------------------------
  logic divided_clock_output_mode;

  assign divided_clock_output_mode = (mode_q == osss_pkg::OSSS_RC_DIVIDED_CLOCK_OUTPUT) || (mode_q == osss_pkg::OSSS_INT_DIVIDED_CLOCK_OUTPUT);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      secondary_oscillator_pin_out  <= 1'b0;
      secondary_oscillator_pin_oe_n <= 1'b1;
    end else begin
      secondary_oscillator_pin_out  <= divided_clock_output_mode & div_cnt_q[1];
      secondary_oscillator_pin_oe_n <= ~(divided_clock_output_mode & cfg_loaded_q);
    end
  end

  // R7 R11 R13 R14 pin release by mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      primary_pin_gpio   <= 1'b0;
      secondary_pin_gpio <= 1'b0;
    end else begin
      primary_pin_gpio   <= is_internal(mode_q);
      secondary_pin_gpio <= (mode_q == osss_pkg::OSSS_EXT_CLOCK) || (mode_q == osss_pkg::OSSS_RC_PIN) ||
                            (mode_q == osss_pkg::OSSS_INT_PINS);
    end
  end

  // R9 gain per crystal mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      amplifier_gain <= osss_pkg::OSSS_GAIN_OFF;
    end else begin
      case (mode_q)
        osss_pkg::OSSS_LOW_XTAL:  amplifier_gain <= osss_pkg::OSSS_GAIN_LOW;
        osss_pkg::OSSS_MED_XTAL:  amplifier_gain <= osss_pkg::OSSS_GAIN_MED;
        osss_pkg::OSSS_HIGH_XTAL: amplifier_gain <= osss_pkg::OSSS_GAIN_HIGH;
        default:                  amplifier_gain <= osss_pkg::OSSS_GAIN_OFF;
      endcase
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // R18 upper trim bits read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `OSSS_ADDR_TRIM:   reg_rdata <= {3'h0, trim_value_q};
        `OSSS_ADDR_STATUS: reg_rdata <= {clock_stable, core_hold, state_q, mode_q};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // R3 hold matches sequencer
  a_hold_until_run: assert property (@(posedge clk_sys) disable iff (!reset_n) // R3
    1'b1 |=> core_hold == ($past(state_q) != osss_pkg::OSSS_ST_RUN))
    else $error("core hold does not follow start-up state");

  // R1 crystal delay needs full count
  a_startup_full_count: assert property (@(posedge clk_sys) disable iff (!reset_n) // R1
    (state_q == osss_pkg::OSSS_ST_DELAY && is_crystal(mode_q)) ##1 (state_q == osss_pkg::OSSS_ST_RUN)
    |-> $past(delay_cnt_q) == 11'h3FF)
    else $error("crystal start-up ended before 1024 edges");

  // R4 short delay count
  a_ext_two_cycles: assert property (@(posedge clk_sys) disable iff (!reset_n) // R4
    (state_q == osss_pkg::OSSS_ST_DELAY && !is_crystal(mode_q) && !is_internal(mode_q))
    ##1 (state_q == osss_pkg::OSSS_ST_RUN) |-> $past(delay_cnt_q) == 11'h007)
    else $error("external start-up delay not two instruction cycles");

  // R2 wake restarts count
  a_wake_restart: assert property (@(posedge clk_sys) disable iff (!reset_n) // R2
    (state_q == osss_pkg::OSSS_ST_SLEEP && wake_event)
    |=> (state_q == osss_pkg::OSSS_ST_DELAY && delay_cnt_q == 11'h000))
    else $error("wake-up did not restart start-up count");

  // R9 high crystal mode gives high gain
  a_gain_high: assert property (@(posedge clk_sys) disable iff (!reset_n) // R9
    $stable(mode_q) && mode_q == osss_pkg::OSSS_HIGH_XTAL |=> amplifier_gain == osss_pkg::OSSS_GAIN_HIGH)
    else $error("high gain crystal mode without high gain");

  // R14 both pins free
  a_pins_free: assert property (@(posedge clk_sys) disable iff (!reset_n) // R14
    $stable(mode_q) && mode_q == osss_pkg::OSSS_INT_PINS |=> primary_pin_gpio && secondary_pin_gpio &&
    secondary_oscillator_pin_oe_n)
    else $error("internal pins-free mode still holds a pin");

  // R10 divider counts edges
  a_div_by_four: assert property (@(posedge clk_sys) disable iff (!reset_n) // R10
    osc_tick |=> div_cnt_q == $past(div_cnt_q) + 2'b01)
    else $error("divided clock missed an oscillator edge");

  // R18 reserved bits zero
  a_trim_read_zero: assert property (@(posedge clk_sys) disable iff (!reset_n) // R18
    reg_read && reg_addr == `OSSS_ADDR_TRIM |=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(trim_value_q))
    else $error("trim read returns wrong data");

  // R17 slew moves at most one step
  a_slew_gradual: assert property (@(posedge clk_sys) disable iff (!reset_n) // R17
    cfg_loaded_q |=> (inc_q == $past(inc_q)) || (inc_q == $past(inc_q) + 16'h0001) ||
    (inc_q == $past(inc_q) - 16'h0001))
    else $error("internal frequency jumped");

endmodule

//--- osss_osc_model.sv
// Behavioural external oscillator driving the primary oscillator pin
`timescale 1ns/1ps
module osss_osc_model #(
  parameter int HALF = 3
) (
  // Clock
  input  wire logic clk_sys,
  // Control
  input  wire logic run,
  // Pin
  output logic      osc_pin
);
  int cnt = 0;
  // far side drives clock, stands still when stopped
  always @(posedge clk_sys) begin
    if (!run) begin
      cnt     <= 0;
      osc_pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt     <= 0;
      osc_pin <= ~osc_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

//--- oscillator_source_select_startup_tb.sv
// Self-checking bench for the clock source block
`timescale 1ns/1ps
module oscillator_source_select_startup_tb;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  cfg_sel = 3'h0;
  logic        ifs     = 1'b0;
  logic        pwr_en  = 1'b0;
  logic        pwr_exp = 1'b0;
  logic        sleep_r = 1'b0;
  logic        wake    = 1'b0;
  logic        osc_run = 1'b0;
  logic        osc_pin;
  logic        sec_out, sec_oe_n, pri_gpio, sec_gpio, core_hold, stable, sce;
  logic [1:0]  gain;
  logic [15:0] incr;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [7:0]  reg_rdata, rd_val;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          cyc_cnt = 0;
  int          edges, cycles, sce_cnt, out_cnt;

  always #2 clk_sys = ~clk_sys;

  osss_osc_model osss_osc_model_i (.clk_sys(clk_sys), .run(osc_run), .osc_pin(osc_pin));

  osss_top osss_top_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .clock_source_select(cfg_sel),
    .internal_frequency_select(ifs), .powerup_delay_timer_enable(pwr_en),
    .powerup_delay_timer_expired(pwr_exp), .sleep_request(sleep_r), .wake_event(wake),
    .primary_oscillator_pin_in(osc_pin), .secondary_oscillator_pin_out(sec_out),
    .secondary_oscillator_pin_oe_n(sec_oe_n), .primary_pin_gpio(pri_gpio),
    .secondary_pin_gpio(sec_gpio), .amplifier_gain(gain), .core_hold(core_hold),
    .clock_stable(stable), .system_clock_enable(sce), .internal_oscillator_increment(incr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata)
  );

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 90000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(posedge clk_sys);
    rd_val = reg_rdata;
  endtask

  // Counts enable pulses and divided clock rises over n cycles, sampled at each edge
  task automatic count_win(input int n);
    logic po;
    sce_cnt = 0;
    out_cnt = 0;
    po      = sec_out;
    repeat (n) begin
      @(posedge clk_sys);
      if (sce === 1'b1) sce_cnt++;
      if (sec_out === 1'b1 && po === 1'b0) out_cnt++;
      po = sec_out;
    end
  endtask

  // Reset with a new configuration word; oscillator starts three cycles after reset is released
  task automatic do_reset(input logic [2:0] m, input logic f);
    @(posedge clk_sys);
    osc_run <= 1'b0;
    reset_n <= 1'b0;
    cfg_sel <= m;
    ifs     <= f;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    osc_run <= 1'b1;
  endtask

  // Counts oscillator rises and cycles until the core is released
  task automatic wait_run;
    logic prev;
    edges  = 0;
    cycles = 0;
    #1 prev = osc_pin;
    while (core_hold !== 1'b0 && cycles < 20000) begin
      @(posedge clk_sys);
      #1 cycles++;
      if (osc_pin && !prev) edges++;
      prev = osc_pin;
    end
    check(16'(core_hold), 16'h0000);
  endtask

  task automatic t_regs;
    do_reset(osss_pkg::OSSS_EXT_CLOCK, 1'b0);
    reg_rd(4'h0);
    check(16'(rd_val), 16'h0000);
    reg_wr(4'h0, 8'hFF);
    reg_rd(4'h0);
    check(16'(rd_val), 16'h001F);
    reg_rd(4'h5);
    check(16'(rd_val), 16'h0000);
    $display("Test registers done");
  endtask

  task automatic t_xtal;
    for (int m = 1; m <= 3; m++) begin
      do_reset(3'(m), 1'b0);
      check(16'(gain), 16'(m));
      check(16'(core_hold), 16'h0001);
      wait_run();
      check(16'(edges), 16'd1024);
      check(16'(sec_gpio), 16'h0000);
    end
    reg_rd(4'h1);
    check(16'(rd_val), 16'h009B);
    reg_wr(4'h1, 8'h00);
    reg_rd(4'h1);
    check(16'(rd_val), 16'h009B);
    osc_run <= 1'b0;
    sleep_r <= 1'b1;
    @(posedge clk_sys);
    sleep_r <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(16'(core_hold), 16'h0001);
    wake <= 1'b1;
    @(posedge clk_sys);
    wake <= 1'b0;
    repeat (2) @(posedge clk_sys);
    osc_run <= 1'b1;
    wait_run();
    check(16'(edges), 16'd1024);
    $display("Test crystal done");
  endtask

  task automatic t_ext;
    do_reset(osss_pkg::OSSS_EXT_CLOCK, 1'b0);
    wait_run();
    check(16'(edges), 16'd8);
    check({14'h0, sec_gpio, sec_oe_n}, 16'h0003);
    check(16'(pri_gpio), 16'h0000);
    @(posedge clk_sys);
    osc_run <= 1'b0;
    repeat (4) @(posedge clk_sys);
    count_win(36);
    check(16'(sce_cnt), 16'h0000);
    reg_rd(4'h1);
    check(16'(rd_val), 16'h0098);
    osc_run <= 1'b1;
    count_win(20);
    check(16'(sce_cnt), 16'h0003);
    check(16'(core_hold), 16'h0000);
    $display("Test external clock done");
  endtask

  // Power-up delay holds the start-up count until it expires
  task automatic t_pwrup;
    @(posedge clk_sys);
    pwr_en <= 1'b1;
    do_reset(osss_pkg::OSSS_EXT_CLOCK, 1'b0);
    repeat (100) @(posedge clk_sys);
    check({14'h0, core_hold, stable}, 16'h0002);
    reg_rd(4'h1);
    check(16'(rd_val), 16'h0048);
    pwr_exp <= 1'b1;
    wait_run();
    check(16'(edges), 16'd8);
    @(posedge clk_sys);
    pwr_en  <= 1'b0;
    pwr_exp <= 1'b0;
    $display("Test power-up delay done");
  endtask

  task automatic t_rc;
    int r;
    int o;
    logic pp;
    logic po;
    do_reset(osss_pkg::OSSS_RC_DIVIDED_CLOCK_OUTPUT, 1'b0);
    wait_run();
    check(16'(edges), 16'd8);
    check(16'(sec_oe_n), 16'h0000);
    r = 0;
    o = 0;
    pp = osc_pin;
    po = sec_out;
    while (r < 40) begin
      @(posedge clk_sys);
      #1 if (osc_pin && !pp) r++;
      if (sec_out && !po) o++;
      pp = osc_pin;
      po = sec_out;
    end
    check(16'(o), 16'd10);
    do_reset(osss_pkg::OSSS_RC_PIN, 1'b0);
    wait_run();
    check({14'h0, sec_gpio, sec_oe_n}, 16'h0003);
    $display("Test RC done");
  endtask

  task automatic t_int;
    do_reset(osss_pkg::OSSS_INT_DIVIDED_CLOCK_OUTPUT, 1'b1);
    wait_run();
    check(16'(cycles >= 495 && cycles <= 510), 16'h0001);
    check({14'h0, pri_gpio, sec_oe_n}, 16'h0002);
    check(incr, 16'h0831);
    count_win(1000);
    check(16'(sce_cnt >= 31 && sce_cnt <= 32), 16'h0001);
    check(16'(out_cnt >= 7 && out_cnt <= 8), 16'h0001);
    reg_wr(4'h0, 8'h0F);
    repeat (64) @(posedge clk_sys);
    check(16'(incr === 16'h0921), 16'h0000);
    check(16'(core_hold), 16'h0000);
    repeat (16000) @(posedge clk_sys);
    check(incr, 16'h0921);
    reg_wr(4'h0, 8'h10);
    repeat (32000) @(posedge clk_sys);
    check(incr, 16'h0731);
    reg_rd(4'h0);
    check(16'(rd_val), 16'h0010);
    do_reset(osss_pkg::OSSS_INT_PINS, 1'b0);
    wait_run();
    check({14'h0, pri_gpio, sec_gpio}, 16'h0003);
    check(incr, 16'h0418);
    $display("Test internal done");
  endtask

  initial begin
    t_regs();
    t_xtal();
    t_ext();
    t_pwrup();
    t_rc();
    t_int();
    report_and_stop();
  end
endmodule
